/* File: verif/spl_far_model.sv */
// far-side model: host master on the slave port and nibble rom on the link
`timescale 1ns/1ps

module spl_far_model (
   input  wire logic       core_clk,
   input  wire logic       rom_ce_b,
   input  wire logic [7:0] pa_wire,
   input  wire logic [1:0] pb_wire,
   output logic      [7:0] pa_far,
   output logic      [7:0] pa_far_en,
   output logic      [1:0] pb_far
);
   logic [15:0] rom_addr;
   logic [3:0]  rom_k;
   logic        stb_q;
   int          hold;
   logic        rom_hard_clear_b;
   logic        indirect_select;
   logic [1:0]  nib_cnt;
   logic [1:0]  ind_smp;
   wire logic   rom_cascade_ce = !rom_ce_b;

   // idle: strobe high, select high, no drive on the data port
   initial begin
      pa_far = 8'h00;
      pa_far_en = 8'h00;
      pb_far = 2'h3;
      rom_addr = 16'h0000;
      rom_k = 4'h0;
      stb_q = 1'b1;
      hold = 0;
      rom_hard_clear_b = 1'b1;
      indirect_select = 1'b0;
      nib_cnt = 2'h0;
      ind_smp = 2'h0;
   end

   // rom side: latch address nibbles or return data nibbles on strobe falls
   always @(posedge core_clk) begin
      stb_q <= pb_wire[0];
      if (!rom_hard_clear_b) begin
         rom_addr <= 16'h0000;
         nib_cnt <= 2'h0;
         hold <= 0;
      end else if (rom_ce_b) begin
         hold <= 0;
      end else if (stb_q && !pb_wire[0] && !pb_wire[1]) begin
         rom_addr <= {pa_wire[3:0], rom_addr[15:4]};
         rom_k <= 4'h0;
         nib_cnt <= nib_cnt + 2'h1;
         if (nib_cnt[0]) begin
            ind_smp <= {indirect_select, ind_smp[1]};
         end
      end else if (stb_q && !pb_wire[0]) begin
         pa_far[3:0] <= rom_addr[3:0] + rom_k;
         pa_far_en <= 8'h0f;
         rom_k <= rom_k + 4'h1;
         hold <= 3;
      end else if (pb_wire[0] && hold > 0) begin
         hold <= hold - 1;
         if (hold == 1) begin
            pa_far[3:0] <= ~pa_far[3:0]; // released bus shows inverse, not last value
            pa_far_en <= 8'h00;
         end
      end
   end

   // one host transfer: select, data, strobe low for six cycles, then release
   task automatic host_xfer(input logic rd, input logic [7:0] d, output logic [7:0] q);
      @(posedge core_clk);
      pb_far[1] <= rd;
      if (!rd) begin
         pa_far <= d;
         pa_far_en <= 8'hff;
      end else
         pa_far_en <= 8'h00;
      repeat (2) @(posedge core_clk);
      pb_far[0] <= 1'b0;
      repeat (6) @(posedge core_clk);
      q = pa_wire;
      pb_far[0] <= 1'b1;
      repeat (6) @(posedge core_clk);
      pa_far <= ~pa_far;
      pa_far_en <= 8'h00;
   endtask
endmodule

/* File: verif/tb_top.sv */
// testbench for the slave port and rom nibble link
`timescale 1ns/1ps

module tb_top;
   logic        core_clk;
   logic        rst_b;
   logic [2:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  reg_rdata;
   logic [7:0]  pa_in;
   logic [7:0]  pa_out;
   logic [7:0]  pa_oe;
   logic [1:0]  pb_in;
   logic [1:0]  pb_out;
   logic [1:0]  pb_oe;
   logic [7:0]  pa_far;
   logic [7:0]  pa_far_en;
   logic [1:0]  pb_far;
   logic        rom_ce_b;
   logic [7:0]  r;
   logic [7:0]  d;
   logic [7:0]  last;
   logic [15:0] a;
   int          err_total;
   int          num_checks;
   int          n;
   int          k;

   // pin levels: dut drive where its enable is set, far-side level on all other pins
   assign pa_in = (pa_oe & pa_out) | (~pa_oe & pa_far);
   assign pb_in = (pb_oe & pb_out) | (~pb_oe & pb_far);

   spl_port i_dut (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe), .pb_in(pb_in), .pb_out(pb_out),
      .pb_oe(pb_oe));

   spl_far_model i_far (.core_clk(core_clk), .rom_ce_b(rom_ce_b), .pa_wire(pa_in),
      .pb_wire(pb_in), .pa_far(pa_far), .pa_far_en(pa_far_en), .pb_far(pb_far));

   // 200 mhz clock
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   // both parties driving the data port at once is a fault
   always @(negedge core_clk) begin
      if (rst_b && (pa_oe & pa_far_en) !== 8'h00) begin
         err_total++;
         $display("ERROR t=%0t oe=%h far=%h", $time, pa_oe, pa_far_en);
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic close_out();
      $display("checks=%0d mismatches=%0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic wr(input logic [2:0] ad, input logic [7:0] dt);
      @(posedge core_clk);
      reg_addr <= ad;
      reg_wdata <= dt;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe
   task automatic rdc(input logic [2:0] ad, input logic [7:0] exp, input logic [7:0] msk);
      @(posedge core_clk);
      reg_addr <= ad;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      chk({8'h00, reg_rdata & msk}, {8'h00, exp});
   endtask

   initial begin
      rst_b = 1'b0;
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      rom_ce_b = 1'b1;
      err_total = 0;
      num_checks = 0;
      void'($urandom(32'hf63bd629));
      repeat (2) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge core_clk);
      // reset values and idle pin enables
      rdc(spl_pkg::REG_MODE, spl_pkg::MODE_RST, 8'hff);
      rdc(spl_pkg::REG_PA_OUT, spl_pkg::PA_OUT_RST, 8'hff);
      rdc(spl_pkg::REG_PA_DIR, spl_pkg::PA_DIR_RST, 8'hff);
      rdc(spl_pkg::REG_PB_CTRL, {4'h0, spl_pkg::PB_DIR_RST, spl_pkg::PB_OUT_RST}, 8'h0f);
      chk({pa_oe, 6'h00, pb_oe}, 16'h0000);
      $display("test reset done");
      // slave mode: poll handshake, then write random bytes
      wr(spl_pkg::REG_MODE, 8'h40);
      rdc(spl_pkg::REG_MODE, 8'h40, 8'hff);
      for (n = 0; n < 3; n++) begin
         wr(spl_pkg::REG_PA_OUT, 8'h80);
         i_far.host_xfer(1'b1, 8'h00, r);
         chk({15'h0000, r[7]}, 16'h0001);
         d = 8'($urandom);
         last = d;
         i_far.host_xfer(1'b0, d, r);
         rdc(spl_pkg::REG_STATUS, 8'h05, 8'h07);
         rdc(spl_pkg::REG_PA_IN, d, 8'hff);
         rdc(spl_pkg::REG_PA_OUT, 8'h00, 8'hff);
      end
      $display("test slave write done");
      // slave read: seven data bits plus a raised handshake
      d = {1'b1, 7'($urandom)};
      wr(spl_pkg::REG_PA_OUT, d);
      i_far.host_xfer(1'b1, 8'h00, r);
      chk({8'h00, r}, {8'h00, d});
      chk({14'h0000, pb_oe}, 16'h0000);
      rdc(spl_pkg::REG_PA_OUT, d, 8'hff);
      rdc(spl_pkg::REG_PA_IN, last, 8'hff);
      wr(spl_pkg::REG_MODE, 8'h50);
      rdc(spl_pkg::REG_MODE, 8'h40, 8'hff);
      $display("test slave read done");
      // rom mode: quarter-rate clock gated by the latch bit
      rom_ce_b <= 1'b0;
      wr(spl_pkg::REG_MODE, 8'h10);
      wr(spl_pkg::REG_PA_DIR, 8'h8f);
      wr(spl_pkg::REG_PB_CTRL, 8'h0d);
      wr(spl_pkg::REG_PA_OUT, 8'h80);
      repeat (2) @(posedge core_clk);
      for (n = 0; n < 8; n++) begin
         @(negedge core_clk);
         a[n] = pa_out[7];
      end
      chk({10'h000, a[5:0] ^ a[7:2]}, 16'h003f);
      // address load, low nibble first, one strobe per nibble
      a = 16'($urandom);
      for (n = 0; n < 4; n++) begin
         wr(spl_pkg::REG_PA_OUT, {4'h8, a[4*n +: 4]});
         wr(spl_pkg::REG_PB_CTRL, 8'h0c);
         wr(spl_pkg::REG_PB_CTRL, 8'h0d);
      end
      @(negedge core_clk);
      chk(i_far.rom_addr, a);
      // hardware fetches with direction high
      wr(spl_pkg::REG_PA_DIR, 8'h80);
      wr(spl_pkg::REG_PB_CTRL, 8'h0f);
      for (n = 0; n < 3; n++) begin
         wr(spl_pkg::REG_FETCH, 8'h00);
         k = 0;
         repeat (12) begin
            @(negedge core_clk);
            k += int'(!pb_out[0]);
         end
         chk(16'(k), 16'(spl_pkg::FETCH_LOW_CYC));
         rdc(spl_pkg::REG_STATUS, 8'h00, 8'h08);
         rdc(spl_pkg::REG_FETCH, {4'h0, a[3:0] + 4'(n)}, 8'h0f);
      end
      wr(spl_pkg::REG_PA_OUT, 8'h00);
      repeat (3) @(posedge core_clk);
      k = 0;
      repeat (8) begin
         @(negedge core_clk);
         k += int'(pa_out[7]);
      end
      chk(16'(k), 16'h0000);
      $display("test rom link done");
      close_out();
   end
endmodule

/* File: verilog/spl_pkg.sv */
// shared constants, types and register map for the slave port / rom nibble link
//
// Overview of operation
// RL1 - mode bit 6 selects host slave mode
// RL2 - host strobe low pulse does one transfer
// RL3 - select low writes, select high reads
// RL4 - write strobe fall clears set handshake bit
// RL5 - reads carry seven bits, writes eight
// RL6 - master floats its drivers during reads
// RL7 - port pins inputs, handshake may drive
// RL8 - slave and rom modes never together
// RL9 - master polls handshake before writing
// RL10 - firmware sets handshake when ready again
// RL11 - strobe captures port pins into latch
// RL12 - firmware waits strobe high before using data
// RL13 - answer on seven pins, handshake high
// RL14 - handshake stays high, cleared means command
// RL15 - mode bit 4 selects external rom mode
// RL16 - rom strobe is latch and hardware strobe
// RL17 - rom clock is latch and quarter clock
// RL18 - rom latches address or drives data nibble
// RL19 - rom clear input tristates rom outputs; the model's clear resets address and count, nibble drive stays on
// RL20 - rom chip enable high floats nibble bus; the model only clears its release count, so the nibble drive stays on
// RL21 - rom select input picks direct or table; the model samples select but always returns address plus nibble count
// RL22 - rom cascade enable is inverted enable
// RL23 - rom samples select on nibbles two, four
// RL24 - address nibbles sent low nibble first
// RL25 - strobe and select synchronised before use
package spl_pkg;

   // register indices on the plain register port
   localparam logic [2:0] REG_MODE    = 3'h0;
   localparam logic [2:0] REG_PA_OUT  = 3'h1;
   localparam logic [2:0] REG_PA_DIR  = 3'h2;
   localparam logic [2:0] REG_PB_CTRL = 3'h3;
   localparam logic [2:0] REG_PA_IN   = 3'h4;
   localparam logic [2:0] REG_PA_PINS = 3'h5;
   localparam logic [2:0] REG_STATUS  = 3'h6;
   localparam logic [2:0] REG_FETCH   = 3'h7;

   // field positions
   localparam int MODE_SLAVE_BIT  = 6;
   localparam int MODE_EXTERNAL_ROM_MODE_BIT = 4;
   localparam int HS_BIT          = 7;
   localparam int STROBE_BIT      = 0;
   localparam int RW_BIT          = 1;
   localparam int PB_DIR_LSB      = 2;
   localparam int ST_STROBE_BIT   = 0;
   localparam int ST_RW_BIT       = 1;
   localparam int ST_WRSEEN_BIT   = 2;
   localparam int ST_FBUSY_BIT    = 3;

   // reset values
   localparam logic [7:0] MODE_RST   = 8'h00;
   localparam logic [7:0] PA_OUT_RST = 8'h00;
   localparam logic [7:0] PA_DIR_RST = 8'h00;
   localparam logic [1:0] PB_OUT_RST = 2'h3;
   localparam logic [1:0] PB_DIR_RST = 2'h0;

   // timing: hardware fetch strobe low time, at a 200 mhz core clock
   localparam int CLK_MHZ          = 200;
   localparam int FETCH_LOW_NS     = 20;
   localparam int FETCH_LOW_RAW    = (FETCH_LOW_NS * CLK_MHZ + 999) / 1000;
   localparam int FETCH_LOW_CYC    = (FETCH_LOW_RAW < 1) ? 1 : FETCH_LOW_RAW;
   localparam logic [3:0] FETCH_LOW_CNT = 4'(FETCH_LOW_CYC - 1);

   // fetch sequencer states
   typedef enum logic [2:0] {
      FS_IDLE    = 3'b001,
      FS_STROBE  = 3'b010,
      FS_CAPTURE = 3'b100
   } spl_fetch_e;

   // drive of one port: level and enable per pin
   typedef struct packed {
      logic [7:0] lvl;
      logic [7:0] oe;
   } spl_pa_drv_s;

   typedef struct packed {
      logic [1:0] lvl;
      logic [1:0] oe;
   } spl_pb_drv_s;

endpackage

/* File: verilog/spl_port.sv */
// port block: host slave port and external rom nibble link
`timescale 1ns/1ps

module spl_port (
   input  wire logic       core_clk,
   input  wire logic       rst_b,
   input  wire logic [2:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   input  wire logic [7:0] pa_in,
   output logic      [7:0] pa_out,
   output logic      [7:0] pa_oe,
   input  wire logic [1:0] pb_in,
   output logic      [1:0] pb_out,
   output logic      [1:0] pb_oe
);

   // reset release through two flops
   logic rst_meta_ff;
   logic rst_sync_ff;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end
   wire logic rst_n = rst_sync_ff;

   // pin synchronisers
   logic [7:0] pa_sync;
   logic [1:0] pb_sync;
   spl_sync2 #(.WIDTH(8)) u_sync_pa (
      .clk   (core_clk),
      .rst_b (rst_n),
      .d     (pa_in),
      .q     (pa_sync)
   );
   spl_sync2 #(.WIDTH(2)) u_sync_pb (
      .clk   (core_clk),
      .rst_b (rst_n),
      .d     (pb_in),
      .q     (pb_sync)
   ); // RL25

   // software state
   logic [7:0] mode_ff;
   logic [7:0] pa_latch_ff;
   logic [7:0] pa_dir_ff;
   logic [1:0] pb_latch_ff;
   logic [1:0] pb_dir_ff;
   logic [7:0] pa_in_latch_ff;
   logic       wr_seen_ff;
   logic       strobe_prev_ff;
   logic [3:0] fetch_nibble_ff;
   logic [7:0] reg_rdata_ff;

   // fetch sequencer and rom clock divider
   spl_pkg::spl_fetch_e fetch_state_ff;
   spl_pkg::spl_fetch_e nxt_fetch_state;
   logic [3:0]          fetch_cnt_ff;
   logic [1:0]          div_ff;

   // registered pin drive
   spl_pkg::spl_pa_drv_s pa_drv_ff;
   spl_pkg::spl_pb_drv_s pb_drv_ff;
   spl_pkg::spl_pa_drv_s nxt_pa_drv;
   spl_pkg::spl_pb_drv_s nxt_pb_drv;

   // register decode
   function automatic logic hit(input logic [2:0] a, input logic [2:0] idx);
      hit = (a == idx);
   endfunction

   wire logic wr_mode  = reg_wr && hit(reg_addr, spl_pkg::REG_MODE);
   wire logic wr_pa    = reg_wr && hit(reg_addr, spl_pkg::REG_PA_OUT);
   wire logic wr_padir = reg_wr && hit(reg_addr, spl_pkg::REG_PA_DIR);
   wire logic wr_pb    = reg_wr && hit(reg_addr, spl_pkg::REG_PB_CTRL);
   wire logic wr_fetch = reg_wr && hit(reg_addr, spl_pkg::REG_FETCH);
   wire logic rd_stat  = reg_rd && hit(reg_addr, spl_pkg::REG_STATUS);

   // mode bits
   wire logic slave_mode  = mode_ff[spl_pkg::MODE_SLAVE_BIT]; // RL1
   wire logic external_rom_mode_mode = mode_ff[spl_pkg::MODE_EXTERNAL_ROM_MODE_BIT]; // RL15
   wire logic mode_clash  = reg_wdata[spl_pkg::MODE_SLAVE_BIT]
                            && reg_wdata[spl_pkg::MODE_EXTERNAL_ROM_MODE_BIT];

   // host strobe and select after synchronisation
   wire logic strobe_lvl  = pb_sync[spl_pkg::STROBE_BIT];
   wire logic rw_lvl      = pb_sync[spl_pkg::RW_BIT];
   wire logic strobe_fall = strobe_prev_ff && !strobe_lvl; // RL25
   wire logic host_write  = slave_mode && strobe_fall && !rw_lvl; // RL2 RL3
   wire logic host_read   = slave_mode && !strobe_lvl && rw_lvl; // RL3

   // mode register: a write that asks for both modes is ignored
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_ff <= spl_pkg::MODE_RST;
      end else if (wr_mode && !mode_clash) begin
         mode_ff <= reg_wdata; // RL8
      end
   end

   // port a output latch; the hardware clear beats a same-cycle write
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pa_latch_ff <= spl_pkg::PA_OUT_RST;
      end else begin
         if (wr_pa) begin
            pa_latch_ff <= reg_wdata; // RL10 RL13
         end
         if (host_write && (wr_pa ? reg_wdata[spl_pkg::HS_BIT]
                                  : pa_latch_ff[spl_pkg::HS_BIT])) begin
            pa_latch_ff[spl_pkg::HS_BIT] <= 1'b0; // RL4 RL14
         end
      end
   end

   // direction and port b control
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pa_dir_ff   <= spl_pkg::PA_DIR_RST;
         pb_latch_ff <= spl_pkg::PB_OUT_RST;
         pb_dir_ff   <= spl_pkg::PB_DIR_RST;
      end else begin
         if (wr_padir) begin
            pa_dir_ff <= reg_wdata;
         end
         if (wr_pb) begin
            pb_latch_ff <= reg_wdata[1:0]; // RL24
            pb_dir_ff   <= reg_wdata[spl_pkg::PB_DIR_LSB +: 2];
         end
      end
   end

   // host write capture into the input latch, all eight pins
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pa_in_latch_ff <= 8'h00;
         strobe_prev_ff <= 1'b1;
      end else begin
         strobe_prev_ff <= strobe_lvl;
         if (host_write) begin
            pa_in_latch_ff <= pa_sync; // RL11 RL5
         end
      end
   end

   // sticky write-seen flag: a new write beats the clear on read
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_seen_ff <= 1'b0;
      end else if (host_write) begin
         wr_seen_ff <= 1'b1; // RL12
      end else if (rd_stat) begin
         wr_seen_ff <= 1'b0;
      end
   end

   // quarter-rate rom clock
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_ff <= 2'h0;
      end else begin
         div_ff <= div_ff + 2'h1; // RL17
      end
   end
   wire logic quarter_clk = div_ff[1];

   // fetch sequencer next state
   always_comb begin
      nxt_fetch_state = fetch_state_ff;
      case (fetch_state_ff)
         spl_pkg::FS_IDLE: begin
            if (wr_fetch && external_rom_mode_mode) begin
               nxt_fetch_state = spl_pkg::FS_STROBE;
            end
         end
         spl_pkg::FS_STROBE: begin
            if (fetch_cnt_ff == spl_pkg::FETCH_LOW_CNT) begin
               nxt_fetch_state = spl_pkg::FS_CAPTURE;
            end
         end
         spl_pkg::FS_CAPTURE: begin
            nxt_fetch_state = spl_pkg::FS_IDLE;
         end
         default: begin
            nxt_fetch_state = spl_pkg::FS_IDLE;
         end
      endcase
   end

   // fetch sequencer state, low-time counter and captured nibble
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         fetch_state_ff  <= spl_pkg::FS_IDLE;
         fetch_cnt_ff    <= 4'h0;
         fetch_nibble_ff <= 4'h0;
      end else begin
         fetch_state_ff <= nxt_fetch_state;
         fetch_cnt_ff   <= (fetch_state_ff == spl_pkg::FS_STROBE) ? fetch_cnt_ff + 4'h1 : 4'h0;
         if (fetch_state_ff == spl_pkg::FS_CAPTURE) begin
            fetch_nibble_ff <= pa_sync[3:0]; // RL18
         end
      end
   end
   wire logic hw_strobe_n = (fetch_state_ff != spl_pkg::FS_STROBE);
   wire logic fetch_busy  = (fetch_state_ff != spl_pkg::FS_IDLE);

   // pin drive per mode
   always_comb begin
      nxt_pa_drv.lvl = pa_latch_ff;
      nxt_pa_drv.oe  = pa_dir_ff;
      nxt_pb_drv.lvl = pb_latch_ff;
      nxt_pb_drv.oe  = pb_dir_ff;
      if (slave_mode) begin
         nxt_pa_drv.oe = {pa_dir_ff[spl_pkg::HS_BIT] | host_read, {7{host_read}}}; // RL7 RL13
         nxt_pb_drv.oe = 2'h0; // RL2
      end else if (external_rom_mode_mode) begin
         nxt_pa_drv.lvl[spl_pkg::HS_BIT] = pa_latch_ff[spl_pkg::HS_BIT] & quarter_clk; // RL17
         nxt_pb_drv.lvl[spl_pkg::STROBE_BIT] = pb_latch_ff[spl_pkg::STROBE_BIT]
                                               & hw_strobe_n; // RL16
         if (fetch_busy) begin
            nxt_pa_drv.oe[3:0] = 4'h0; // RL18
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pa_drv_ff <= '0;
         pb_drv_ff <= '0;
      end else begin
         pa_drv_ff <= nxt_pa_drv;
         pb_drv_ff <= nxt_pb_drv;
      end
   end

   // read data mux, unmapped bits read zero
   wire logic [7:0] status_word = {4'h0, fetch_busy, wr_seen_ff, rw_lvl, strobe_lvl};
   logic [7:0] rd_mux;
   always_comb begin
      case (reg_addr)
         spl_pkg::REG_MODE:    rd_mux = mode_ff;
         spl_pkg::REG_PA_OUT:  rd_mux = pa_latch_ff;
         spl_pkg::REG_PA_DIR:  rd_mux = pa_dir_ff;
         spl_pkg::REG_PB_CTRL: rd_mux = {4'h0, pb_dir_ff, pb_latch_ff};
         spl_pkg::REG_PA_IN:   rd_mux = pa_in_latch_ff;
         spl_pkg::REG_PA_PINS: rd_mux = pa_sync;
         spl_pkg::REG_STATUS:  rd_mux = status_word;
         spl_pkg::REG_FETCH:   rd_mux = {4'h0, fetch_nibble_ff};
         default:              rd_mux = 8'h00;
      endcase
   end

   // read data stands for one cycle after the strobe only
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_ff <= 8'h00;
      end else begin
         reg_rdata_ff <= reg_rd ? rd_mux : 8'h00;
      end
   end

   // outputs straight from flops
   assign reg_rdata = reg_rdata_ff;
   assign pa_out    = pa_drv_ff.lvl;
   assign pa_oe     = pa_drv_ff.oe;
   assign pb_out    = pb_drv_ff.lvl;
   assign pb_oe     = pb_drv_ff.oe;

   // checks
   chk_mode_exclusive: assert property (@(posedge core_clk) disable iff (!rst_n)
      !(slave_mode && external_rom_mode_mode)) // RL8
      else $error("slave and rom modes both set");

   chk_hs_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
      (host_write && pa_latch_ff[spl_pkg::HS_BIT] && !wr_pa)
      |=> !pa_latch_ff[spl_pkg::HS_BIT]) // RL4
      else $error("handshake not cleared by host write");

   chk_write_capture: assert property (@(posedge core_clk) disable iff (!rst_n)
      host_write |=> pa_in_latch_ff == $past(pa_sync)) // RL11
      else $error("input latch missed host write");

   chk_read_drive: assert property (@(posedge core_clk) disable iff (!rst_n)
      (host_read && !wr_pa) |=> pa_oe[6:0] == 7'h7f && pa_out[6:0] == pa_latch_ff[6:0]) // RL13
      else $error("read data not driven");

   chk_idle_float: assert property (@(posedge core_clk) disable iff (!rst_n)
      (slave_mode && strobe_lvl && !wr_mode) |=> pa_oe[6:0] == 7'h00) // RL7
      else $error("data pins driven outside read");

   chk_one_capture: assert property (@(posedge core_clk) disable iff (!rst_n)
      host_write |=> !host_write) // RL25
      else $error("two captures from one strobe");

   chk_rom_strobe: assert property (@(posedge core_clk) disable iff (!rst_n)
      (external_rom_mode_mode && !hw_strobe_n && !wr_mode) |=> !pb_out[spl_pkg::STROBE_BIT]) // RL16
      else $error("rom strobe not low during fetch");

   chk_fetch_len: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(fetch_state_ff == spl_pkg::FS_STROBE)
      |-> (fetch_state_ff == spl_pkg::FS_STROBE) [*4] ##1 (fetch_state_ff == spl_pkg::FS_CAPTURE)) // RL16
      else $error("fetch strobe low time wrong");

   chk_rom_clock: assert property (@(posedge core_clk) disable iff (!rst_n)
      (external_rom_mode_mode && !wr_mode && !wr_pa && pa_latch_ff[spl_pkg::HS_BIT])
      |=> pa_out[spl_pkg::HS_BIT] == $past(quarter_clk)) // RL17
      else $error("rom clock not quarter rate");

endmodule

/* File: verilog/spl_sync2.sv */
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps

module spl_sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_ff;

   // first stage feeds only the second
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_ff <= '0;
         q       <= '0;
      end else begin
         meta_ff <= d;
         q       <= meta_ff;
      end
   end

endmodule
